//--- common/sbrg_regs.vh
`ifndef SBRG_REGS_VH
`define SBRG_REGS_VH

// byte addresses of the registers
`define SBRG_ADR_TXC 8'h00
`define SBRG_ADR_RXC 8'h04
`define SBRG_ADR_BDC 8'h08
`define SBRG_ADR_DVH 8'h0c
`define SBRG_ADR_DVL 8'h10
`define SBRG_ADR_STS 8'h14

// reset values
`define SBRG_TXC_RST 8'h02
`define SBRG_RXC_RST 8'h00
`define SBRG_BDC_RST 8'h40
`define SBRG_DIV_RST 8'h00

// writable bits of each control register
`define SBRG_TXC_WMASK 8'hfd
`define SBRG_RXC_WMASK 8'hf8
`define SBRG_BDC_WMASK 8'hbb

// field positions
`define SBRG_TXC_SYNC 4
`define SBRG_TXC_HS 2
`define SBRG_RXC_EN 7
`define SBRG_BDC_W16 3
`define SBRG_STS_LEVEL 0
`define SBRG_STS_FILT 1

// terminal counts of the rate prescaler (divide by 64, 16, 4)
`define SBRG_PRE_DIV64 6'h3f
`define SBRG_PRE_DIV16 6'h0f
`define SBRG_PRE_DIV4 6'h03

`endif

//--- rtl/sbrg_top.v
// How it works
// - three receive samples are voted; the majority becomes the received level
// - async, 8-bit divisor, low speed: rate is clock over 64 times (n+1)
// - async, 8-bit divisor, high speed: rate is clock over 16 times (n+1)
// - async, 16-bit divisor, low speed: rate is clock over 16 times (n+1)
// - sync mode ignores high speed; rate is clock over 4 times (n+1)
// - divisor value is the high byte above the low byte
// - the divisor timer runs on the system clock itself
// - baud control bits 2 and 6 ignore writes; bit 2 reads zero and bit 6 reads one
// - the divisor lives in two separate 8-bit registers
// - 8-bit by default; width select adds the high byte
// - a divisor write restarts the timer at once
`include "sbrg_regs.vh"

module sbrg_top (
	// clock and reset
	input wire clk,
	input wire reset,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// serial line
	input wire receive_pin,
	// to transmitter and receiver
	output reg rate_tick,
	output reg bit_tick,
	output reg rx_level
);

	// register file
	reg [7:0] transmit_status_control;
	reg [7:0] receive_status_control;
	reg [7:0] baud_control;
	reg [7:0] divisor_high_byte;
	reg [7:0] divisor_low_byte;

	// bus decode
	wire bus_req;
	wire wr_lane0;
	reg [7:0] next_divisor_high_byte;
	reg [7:0] next_divisor_low_byte;
	reg div_write;
	reg [31:0] next_rdata;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

	// mode selection
	wire sync_mode;
	wire high_speed_select;
	wire divisor_width_select;
	wire port_enable;
	wire [15:0] divisor_value;
	reg [5:0] pre_term;

	// generator state
	reg [15:0] timer;
	reg [15:0] next_timer;
	reg next_rate_tick;
	reg [5:0] prescale;
	reg [5:0] next_prescale;
	reg next_bit_tick;

	// receive sampling
	reg rx_s1;
	reg rx_s2;
	reg rx_s3;
	reg rx_filt;
	reg [1:0] rx_window;
	wire rx_vote;

	// divisor registers written this cycle, used for the restart
	always @* begin
		next_divisor_high_byte = divisor_high_byte;
		next_divisor_low_byte = divisor_low_byte;
		div_write = 1'b0;
		if (wr_lane0 && wb_adr_i == `SBRG_ADR_DVH) begin
			next_divisor_high_byte = wb_dat_i[7:0];
			div_write = 1'b1;
		end
		if (wr_lane0 && wb_adr_i == `SBRG_ADR_DVL) begin
			next_divisor_low_byte = wb_dat_i[7:0];
			div_write = 1'b1;
		end
	end

	// register writes; read-only bits keep their reset value
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			transmit_status_control <= `SBRG_TXC_RST;
			receive_status_control <= `SBRG_RXC_RST;
			baud_control <= `SBRG_BDC_RST;
			divisor_high_byte <= `SBRG_DIV_RST;
			divisor_low_byte <= `SBRG_DIV_RST;
		end else begin
			divisor_high_byte <= next_divisor_high_byte;
			divisor_low_byte <= next_divisor_low_byte;
			if (wr_lane0 && wb_adr_i == `SBRG_ADR_TXC) begin
				transmit_status_control <= (transmit_status_control & ~`SBRG_TXC_WMASK)
					| (wb_dat_i[7:0] & `SBRG_TXC_WMASK);
			end
			if (wr_lane0 && wb_adr_i == `SBRG_ADR_RXC) begin
				receive_status_control <= (receive_status_control & ~`SBRG_RXC_WMASK)
					| (wb_dat_i[7:0] & `SBRG_RXC_WMASK);
			end
			if (wr_lane0 && wb_adr_i == `SBRG_ADR_BDC) begin
				baud_control <= (baud_control & ~`SBRG_BDC_WMASK)
					| (wb_dat_i[7:0] & `SBRG_BDC_WMASK);
			end
		end
	end

	// read mux; unmapped addresses read zero
	always @* begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			`SBRG_ADR_TXC: next_rdata[7:0] = transmit_status_control;
			`SBRG_ADR_RXC: next_rdata[7:0] = receive_status_control;
			`SBRG_ADR_BDC: next_rdata[7:0] = baud_control;
			`SBRG_ADR_DVH: next_rdata[7:0] = divisor_high_byte;
			`SBRG_ADR_DVL: next_rdata[7:0] = divisor_low_byte;
			`SBRG_ADR_STS: begin
				next_rdata[`SBRG_STS_LEVEL] = rx_level;
				next_rdata[`SBRG_STS_FILT] = rx_filt;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// one-cycle ack, dropped in the cycle after
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	assign sync_mode = transmit_status_control[`SBRG_TXC_SYNC];
	assign high_speed_select = transmit_status_control[`SBRG_TXC_HS];
	assign divisor_width_select = baud_control[`SBRG_BDC_W16];
	assign port_enable = receive_status_control[`SBRG_RXC_EN];

	// high byte ignored unless width select is set
	assign divisor_value = divisor_width_select ?
		{next_divisor_high_byte, next_divisor_low_byte} :
		{8'h00, next_divisor_low_byte};

	// prescaler terminal count per mode
	always @* begin
		pre_term = `SBRG_PRE_DIV64;
		if (sync_mode) begin
			pre_term = `SBRG_PRE_DIV4;
		end else if (divisor_width_select && high_speed_select) begin
			pre_term = `SBRG_PRE_DIV4;
		end else if (high_speed_select) begin
			pre_term = `SBRG_PRE_DIV16;
		end else if (divisor_width_select) begin
			pre_term = `SBRG_PRE_DIV16;
		end
	end

	// divisor timer, one tick per n+1 system clocks
	always @* begin
		next_timer = timer;
		next_rate_tick = 1'b0;
		next_prescale = prescale;
		next_bit_tick = 1'b0;
		if (!port_enable || div_write) begin
			next_timer = divisor_value;
			next_prescale = 6'h00;
		end else if (timer == 16'h0000) begin
			next_timer = divisor_value;
			next_rate_tick = 1'b1;
			if (prescale >= pre_term) begin
				next_prescale = 6'h00;
				next_bit_tick = 1'b1;
			end else begin
				next_prescale = prescale + 6'h01;
			end
		end else begin
			next_timer = timer - 16'h0001;
		end
	end

	// counts on the system clock, so it follows any clock change
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			timer <= 16'h0000;
			prescale <= 6'h00;
			rate_tick <= 1'b0;
			bit_tick <= 1'b0;
		end else begin
			timer <= next_timer;
			prescale <= next_prescale;
			rate_tick <= next_rate_tick;
			bit_tick <= next_bit_tick;
		end
	end

	// pin synchroniser; a change counts once stages two and three agree
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
			rx_filt <= 1'b1;
		end else begin
			rx_s1 <= receive_pin;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3) begin
				rx_filt <= rx_s3;
			end
		end
	end

	// majority of the last three samples, one sample per timer tick
	assign rx_vote = (rx_window[1] & rx_window[0]) | (rx_window[1] & rx_filt)
		| (rx_window[0] & rx_filt);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_window <= 2'b11;
			rx_level <= 1'b1;
		end else if (next_rate_tick) begin
			rx_window <= {rx_window[0], rx_filt};
			rx_level <= rx_vote;
		end
	end

endmodule // sbrg_top

//--- tb/sbrg_asserts.sv
module sbrg_asserts (
	// clock, reset
	input wire clk,
	input wire reset,
	// bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// generator
	input wire rate_tick,
	input wire bit_tick,
	input wire rx_level
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	ack_once_a: assert property (take_s |=> wb_ack_o)
		else $error("no ack");
	ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	bdc_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h08 |-> !wb_dat_o[2])
		else $error("bit2 set");
	dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("high bits");
	bit_rate_a: assert property (bit_tick |-> rate_tick)
		else $error("lone bit tick");
	bit_gap_a: assert property (bit_tick |=> !bit_tick [*3])
		else $error("bit gap");
	rx_step_a: assert property ($changed(rx_level) |-> rate_tick || $past(rate_tick))
		else $error("level step");
	div_restart_a: assert property (take_s ##0 (wb_we_i && wb_adr_i inside {8'h0c, 8'h10})
		|=> !rate_tick) else $error("no restart");
endmodule // sbrg_asserts
bind sbrg_top sbrg_asserts u_chk (
	.clk(clk),
	.reset(reset),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.rate_tick(rate_tick),
	.bit_tick(bit_tick),
	.rx_level(rx_level)
);

//--- tb/sbrg_line_model.sv
module sbrg_line_model (
	// clock
	input wire clk,
	// serial line, idle high
	output logic receive_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial receive_pin = 1'b1;
	task automatic pulse_low(input int len);
		receive_pin <= 1'b0;
		repeat (len) @(posedge clk);
		receive_pin <= 1'b1;
	endtask
endmodule // sbrg_line_model

//--- tb/sbrg_tb_top.sv
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; $display("mismatch %0t %h %h", $time, a, e); end end
module sbrg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, cyc = 0, we = 0, ack, rate_tick, bit_tick, rx_level, rx_pin;
	logic [7:0] adr = 0, wd = 0;
	logic [31:0] rd, rq;
	int err_total = 0, checks_done = 0;
	sbrg_top u_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, wd}), .wb_dat_o(rd), .wb_ack_o(ack),
		.receive_pin(rx_pin), .rate_tick(rate_tick), .bit_tick(bit_tick), .rx_level(rx_level));
	sbrg_line_model u_line (.clk(clk), .receive_pin(rx_pin));
	initial forever #5 clk = ~clk;
	task automatic conclude;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, d);
		int n = 0;
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rq = rd;
		cyc <= 0;
		@(posedge clk);
		if (n >= 50) begin
			err_total++;
			conclude();
		end
	endtask
	task automatic regs_scn;
		bus(0, 8'h00, 0);
		`CHK(rq, 32'h02)
		bus(1, 8'h08, 8'hff);
		bus(0, 8'h08, 0);
		`CHK(rq, 32'hfb)
		bus(0, 8'h1c, 0);
		`CHK(rq, 32'h0)
		bus(1, 8'h08, 0);
	endtask
	task automatic rate_scn(input logic [7:0] tx, bd, input int p, n);
		int c = 0;
		bus(1, 8'h00, tx);
		bus(1, 8'h08, bd);
		bus(1, 8'h0c, 8'h01);
		bus(1, 8'h10, 8'h02);
		bus(1, 8'h04, 8'h80);
		while (bit_tick !== 1'b1 && c < 9000) begin
			@(posedge clk);
			#1 c++;
		end
		c = 0;
		do begin
			@(posedge clk);
			#1 c++;
		end while (bit_tick !== 1'b1 && c < 9000);
		`CHK(c, p * (n + 1))
		bus(1, 8'h04, 0);
	endtask
	task automatic rx_scn;
		int k = 0;
		bus(1, 8'h08, 0);
		bus(1, 8'h10, 8'h03);
		bus(1, 8'h04, 8'h80);
		// one low sample out of three
		u_line.pulse_low(4);
		repeat (30) begin
			@(posedge clk);
			k += !rx_level;
		end
		`CHK(k, 0)
		u_line.pulse_low(40);
		`CHK(rx_level, 1'b0)
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		regs_scn();
		rate_scn(8'h00, 8'h00, 64, 2);
		rate_scn(8'h04, 8'h00, 16, 2);
		rate_scn(8'h00, 8'h08, 16, 258);
		rate_scn(8'h04, 8'h08, 4, 258);
		rate_scn(8'h10, 8'h00, 4, 2);
		rate_scn(8'h14, 8'h08, 4, 258);
		rx_scn();
		conclude();
	end
endmodule // sbrg_tb_top
